// [rtl/pav_pkg.sv]
// Constants, types and helpers for the address and output-reset setup block.
// Assumes a PMBus transaction layer that hands over decoded word commands.
package pav_pkg;

  // ************************************************************
  // Command codes
  // ************************************************************
  localparam logic [7:0] CMD_SETUP     = 8'hD2;
  localparam logic [7:0] CMD_ADDR      = 8'hD3;
  localparam logic [7:0] CMD_STORE_ALL = 8'h15;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int SETUP_EXTERNAL_DIVIDER_STATUS_BIT  = 4;
  localparam int SETUP_OUTPUT_RESET_PIN_TH_BIT = 3;
  localparam int SETUP_OUTPUT_RESET_PIN_EN_BIT = 2;
  localparam int SETUP_OVF_SEL_BIT  = 1;
  localparam int SETUP_OVF_DIS_BIT  = 0;
  localparam int ADDR_COMMON_LSB    = 8;
  localparam int ADDR_UNIQUE_LSB    = 0;
  localparam int ADDR_W             = 7;
  localparam logic [3:0]        SETUP_RST = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 7'h00;

  // ************************************************************
  // Thresholds in millivolts
  // ************************************************************
  localparam int MV_W = 13;
  localparam logic [MV_W-1:0] OUTPUT_RESET_PIN_VH_LO_MV = 13'h0258;
  localparam logic [MV_W-1:0] OUTPUT_RESET_PIN_VL_LO_MV = 13'h01F4;
  localparam logic [MV_W-1:0] OUTPUT_RESET_PIN_VH_HI_MV = 13'h044C;
  localparam logic [MV_W-1:0] OUTPUT_RESET_PIN_VL_HI_MV = 13'h0384;
  localparam logic [MV_W-1:0] OVF_M8_LO_MV = 13'h02EE;
  localparam logic [MV_W-1:0] OVF_M4_LO_MV = 13'h05DC;
  localparam logic [MV_W-1:0] OVF_M2_LO_MV = 13'h0BB8;
  localparam logic [MV_W-1:0] OVF_M1_LO_MV = 13'h12C0;
  localparam logic [MV_W-1:0] OVF_M8_HI_MV = 13'h0384;
  localparam logic [MV_W-1:0] OVF_M4_HI_MV = 13'h0708;
  localparam logic [MV_W-1:0] OVF_M2_HI_MV = 13'h0E10;
  localparam logic [MV_W-1:0] OVF_M1_HI_MV = 13'h1770;
  localparam logic [3:0] MANT_8 = 4'h8;
  localparam logic [3:0] MANT_4 = 4'h4;
  localparam logic [3:0] MANT_2 = 4'h2;
  localparam logic [3:0] MANT_1 = 4'h1;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } pav_cmd_s;

  typedef struct packed {
    logic        valid;
    logic        nack;
    logic [15:0] rdata;
  } pav_rsp_s;

  typedef struct packed {
    logic        store;
    logic [3:0]  setup;
    logic [15:0] addr;
  } pav_nvm_s;

  // Setup word as software sees it; bits 15:5 read zero
  function automatic logic [15:0] pav_setup_image(input logic [3:0] wr,
                                                  input logic external_divider_status);
    pav_setup_image = {11'h000, external_divider_status, wr};
  endfunction

  // Fixed overvoltage threshold; zero for an unlisted mantissa
  function automatic logic [MV_W-1:0] pav_ovf_mv(input logic sel,
                                                 input logic [3:0] mant);
    case (mant)
      MANT_8:  pav_ovf_mv = sel ? OVF_M8_HI_MV : OVF_M8_LO_MV;
      MANT_4:  pav_ovf_mv = sel ? OVF_M4_HI_MV : OVF_M4_LO_MV;
      MANT_2:  pav_ovf_mv = sel ? OVF_M2_HI_MV : OVF_M2_LO_MV;
      MANT_1:  pav_ovf_mv = sel ? OVF_M1_HI_MV : OVF_M1_LO_MV;
      default: pav_ovf_mv = 13'h0000;
    endcase
  endfunction

endpackage

// [rtl/pav_ovf_check.sv]
// Fixed overvoltage threshold lookup and fault comparator.
// Assumes the output voltage arrives as a millivolt code on the same clock.
`timescale 1ns/1ps
module pav_ovf_check
  import pav_pkg::*;
(
  input  wire logic            i_clk,
  input  wire logic            i_rst,
  input  wire logic            i_sel,
  input  wire logic            i_disable,
  input  wire logic [3:0]      i_mant,
  input  wire logic [MV_W-1:0] i_vout_mv,
  output logic      [MV_W-1:0] o_th_mv,
  output logic                 o_fault
);

  logic [MV_W-1:0] next_th_mv;
  logic            next_fault;

  // ************************************************************
  // Threshold and fault
  // ************************************************************
  // An unknown mantissa gives a zero threshold, so it never trips
  always_comb begin
    next_th_mv = pav_ovf_mv(i_sel, i_mant);
    next_fault = !i_disable && (o_th_mv != 13'h0000) &&
                 (i_vout_mv > o_th_mv);
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_th_mv <= 13'h0000;
      o_fault <= 1'b0;
    end else begin
      o_th_mv <= next_th_mv;
      o_fault <= next_fault;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // The release edge still loads the reset threshold, so it is skipped
  AST_OVF_LO_M8: assert property (!i_rst && !i_sel &&
    i_mant == MANT_8 |=> o_th_mv == OVF_M8_LO_MV)
    else $error("low table mantissa 8 wrong");
  AST_OVF_HI_M1: assert property (!i_rst && i_sel &&
    i_mant == MANT_1 |=> o_th_mv == OVF_M1_HI_MV)
    else $error("high table mantissa 1 wrong");
  AST_OVF_DIS: assert property (i_disable |=> !o_fault)
    else $error("fault raised while disabled");

endmodule // pav_ovf_check

// [rtl/pav_setup_regs.sv]
// Setup and bus-address registers reached by PMBus word commands.
// Assumes the transaction layer presents one decoded command per pulse.
`timescale 1ns/1ps

module pav_setup_regs
  import pav_pkg::*;
(
  input  wire logic                 I_REF_CLK,
  input  wire logic                 I_RST,
  input  wire pav_pkg::pav_cmd_s    I_CMD,
  input  wire logic                 I_NVM_LOAD,
  input  wire logic [3:0]           I_NVM_SETUP,
  input  wire logic [15:0]          I_NVM_ADDR,
  input  wire logic                 I_EXTERNAL_DIVIDER_STATUS_STRAP,
  input  wire logic                 I_IS_PRIMARY,
  input  wire logic                 I_OUT_RST_PIN_N,
  input  wire logic [3:0]           I_LOOP_MANT,
  input  wire logic [13-1:0]        I_VOUT_MV,
  output pav_pkg::pav_rsp_s         O_RSP,
  output pav_pkg::pav_nvm_s         O_NVM,
  output logic [6:0]                O_RESP_ADDR,
  output logic [13-1:0]             O_OUTPUT_RESET_PIN_VH_MV,
  output logic [13-1:0]             O_OUTPUT_RESET_PIN_VL_MV,
  output logic                      O_BOOT_ACTIVE,
  output logic                      O_BOOT_START,
  output logic                      O_OVF_EN,
  output logic [13-1:0]             O_OVF_TH_MV,
  output logic                      O_OVERVOLTAGE_FAULT
);

  import pav_pkg::*;

  logic [3:0]        setup;
  logic [ADDR_W-1:0] common_addr;
  logic [ADDR_W-1:0] unique_addr;
  logic              external_divider_status;
  logic              pin_low;
  logic [3:0]        next_setup;
  logic [ADDR_W-1:0] next_common_addr;
  logic [ADDR_W-1:0] next_unique_addr;
  logic [ADDR_W-1:0] next_resp_addr;
  pav_rsp_s          next_rsp;
  pav_nvm_s          next_nvm;
  logic [15:0]       addr_image;
  logic              wr_setup;
  logic              wr_addr;
  logic              boot_cond;

  // ************************************************************
  // Command decode and register update
  // ************************************************************
  // Unique field mirrors the common one on a primary device
  always_comb begin
    addr_image = {1'b0, common_addr, 1'b0,
                  I_IS_PRIMARY ? common_addr : unique_addr};
    wr_setup = I_CMD.valid && I_CMD.write && I_CMD.code == CMD_SETUP;
    wr_addr  = I_CMD.valid && I_CMD.write && I_CMD.code == CMD_ADDR;
    next_setup       = setup;
    next_common_addr = common_addr;
    next_unique_addr = unique_addr;
    next_resp_addr   = O_RESP_ADDR;
    // Only bits 3:0 are stored; strap bit and zero bits fall away
    if (wr_setup) begin
      next_setup = I_CMD.wdata[3:0];
    end
    if (wr_addr) begin
      next_common_addr = I_CMD.wdata[ADDR_COMMON_LSB +: ADDR_W];
      next_unique_addr = I_CMD.wdata[ADDR_UNIQUE_LSB +: ADDR_W];
    end
    // Power-up restore is the only path to the answering address
    if (I_NVM_LOAD) begin
      next_setup       = I_NVM_SETUP;
      next_common_addr = I_NVM_ADDR[ADDR_COMMON_LSB +: ADDR_W];
      next_unique_addr = I_NVM_ADDR[ADDR_UNIQUE_LSB +: ADDR_W];
      next_resp_addr   = I_NVM_ADDR[ADDR_COMMON_LSB +: ADDR_W];
    end
    next_rsp.valid = I_CMD.valid;
    next_rsp.nack  = I_CMD.valid && !(I_CMD.code == CMD_SETUP ||
                     I_CMD.code == CMD_ADDR || I_CMD.code == CMD_STORE_ALL);
    next_rsp.rdata = 16'h0000;
    if (I_CMD.valid && !I_CMD.write && I_CMD.code == CMD_SETUP) begin
      next_rsp.rdata = pav_setup_image(setup, external_divider_status);
    end
    if (I_CMD.valid && !I_CMD.write && I_CMD.code == CMD_ADDR) begin
      next_rsp.rdata = addr_image;
    end
    next_nvm.store = I_CMD.valid && I_CMD.code == CMD_STORE_ALL;
    next_nvm.setup = setup;
    next_nvm.addr  = addr_image;
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      setup       <= SETUP_RST;
      common_addr <= ADDR_RST;
      unique_addr <= ADDR_RST;
      O_RESP_ADDR <= ADDR_RST;
      O_RSP       <= '0;
      O_NVM       <= '0;
    end else begin
      setup       <= next_setup;
      common_addr <= next_common_addr;
      unique_addr <= next_unique_addr;
      O_RESP_ADDR <= next_resp_addr;
      O_RSP       <= next_rsp;
      O_NVM       <= next_nvm;
    end
  end

  // ************************************************************
  // Strap, reset pin and analog settings
  // ************************************************************
  // Level-based start covers both a falling pin and a late enable
  always_comb begin
    boot_cond = setup[SETUP_OUTPUT_RESET_PIN_EN_BIT] && pin_low;
  end

  // Strap is sampled every cycle so a read always shows the pin
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      external_divider_status       <= 1'b0;
      pin_low       <= 1'b0;
      O_BOOT_ACTIVE <= 1'b0;
      O_BOOT_START  <= 1'b0;
      O_OUTPUT_RESET_PIN_VH_MV <= OUTPUT_RESET_PIN_VH_LO_MV;
      O_OUTPUT_RESET_PIN_VL_MV <= OUTPUT_RESET_PIN_VL_LO_MV;
      O_OVF_EN      <= 1'b0;
    end else begin
      external_divider_status       <= I_EXTERNAL_DIVIDER_STATUS_STRAP;
      pin_low       <= !I_OUT_RST_PIN_N;
      O_BOOT_ACTIVE <= boot_cond;
      O_BOOT_START  <= boot_cond && !O_BOOT_ACTIVE;
      O_OUTPUT_RESET_PIN_VH_MV <= setup[SETUP_OUTPUT_RESET_PIN_TH_BIT] ? OUTPUT_RESET_PIN_VH_HI_MV
                                                 : OUTPUT_RESET_PIN_VH_LO_MV;
      O_OUTPUT_RESET_PIN_VL_MV <= setup[SETUP_OUTPUT_RESET_PIN_TH_BIT] ? OUTPUT_RESET_PIN_VL_HI_MV
                                                 : OUTPUT_RESET_PIN_VL_LO_MV;
      O_OVF_EN      <= !setup[SETUP_OVF_DIS_BIT];
    end
  end

  // Threshold lookup and comparison live beside the analog sense path
  pav_ovf_check u_ovf (
    .i_clk     (I_REF_CLK),
    .i_rst     (I_RST),
    .i_sel     (setup[SETUP_OVF_SEL_BIT]),
    .i_disable (setup[SETUP_OVF_DIS_BIT]),
    .i_mant    (I_LOOP_MANT),
    .i_vout_mv (I_VOUT_MV),
    .o_th_mv   (O_OVF_TH_MV),
    .o_fault   (O_OVERVOLTAGE_FAULT)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);

  sequence rd_setup;
    I_CMD.valid && !I_CMD.write && I_CMD.code == CMD_SETUP;
  endsequence
  sequence rd_addr;
    I_CMD.valid && !I_CMD.write && I_CMD.code == CMD_ADDR;
  endsequence
  // Enable written from clear while the pin is already held low
  sequence en_rise_pin_low;
    (wr_setup && I_CMD.wdata[SETUP_OUTPUT_RESET_PIN_EN_BIT] && !I_NVM_LOAD &&
     !setup[SETUP_OUTPUT_RESET_PIN_EN_BIT]) ##1 pin_low;
  endsequence

  AST_EXTERNAL_DIVIDER_STATUS_READ: assert property (rd_setup |=>
    O_RSP.rdata[SETUP_EXTERNAL_DIVIDER_STATUS_BIT] == $past(external_divider_status))
    else $error("strap bit readback wrong");
  AST_OUTPUT_RESET_PIN_TH: assert property (##1 O_OUTPUT_RESET_PIN_VH_MV ==
    ($past(setup[SETUP_OUTPUT_RESET_PIN_TH_BIT]) ? OUTPUT_RESET_PIN_VH_HI_MV : OUTPUT_RESET_PIN_VH_LO_MV))
    else $error("reset pin high threshold wrong");
  AST_OUTPUT_RESET_PIN_OFF: assert property (!setup[SETUP_OUTPUT_RESET_PIN_EN_BIT] |=>
    !O_BOOT_ACTIVE) else $error("boot move while disabled");
  AST_OUTPUT_RESET_PIN_ON: assert property (setup[SETUP_OUTPUT_RESET_PIN_EN_BIT] && pin_low
    |=> O_BOOT_ACTIVE) else $error("boot move missing");
  AST_OUTPUT_RESET_PIN_LATE_EN: assert property (en_rise_pin_low |=>
    O_BOOT_START) else $error("late enable did not start move");
  // Outputs launched at the release edge still carry reset values
  AST_OVF_EN: assert property (!I_RST |=> O_OVF_EN ==
    !$past(setup[SETUP_OVF_DIS_BIT])) else $error("fault enable polarity");
  AST_SETUP_ZERO: assert property (rd_setup |=>
    O_RSP.rdata[15:5] == 11'h000) else $error("setup zero bits set");
  AST_ADDR_ANSWER: assert property (rd_addr |=> O_RSP.valid &&
    !O_RSP.nack) else $error("address command not answered");
  AST_RESP_HOLD: assert property (!I_NVM_LOAD |=>
    $stable(O_RESP_ADDR)) else $error("answer address moved early");
  // Compared against the restored word, not only against the copy
  AST_RESTORE: assert property (I_NVM_LOAD |=>
    O_RESP_ADDR == $past(I_NVM_ADDR[ADDR_COMMON_LSB +: ADDR_W]) &&
    common_addr == O_RESP_ADDR) else $error("restore mismatch");
  AST_ADDR_RSVD: assert property (rd_addr |=> !O_RSP.rdata[15] &&
    !O_RSP.rdata[7]) else $error("reserved address bit set");
  AST_UNIQUE_MIRROR: assert property ((rd_addr and I_IS_PRIMARY) |=>
    O_RSP.rdata[6:0] == O_RSP.rdata[14:8])
    else $error("unique field not mirrored");
  AST_SETUP_KEEP: assert property (wr_setup && !I_NVM_LOAD |=>
    setup == $past(I_CMD.wdata[3:0])) else $error("setup write lost");

  COV_BOOT: cover property (O_BOOT_START);
  COV_STORE: cover property (O_NVM.store);
  COV_FAULT: cover property (O_OVERVOLTAGE_FAULT);
  COV_ADDR_WR: cover property (wr_addr ##1 rd_addr);

endmodule // pav_setup_regs

// [dv/pav_host_model.sv]
// Word-command host model that stands on the command side of the block.
// Assumes the bench calls xfer and the block samples on rising edges.
`timescale 1ns/1ps
module pav_host_model
  import pav_pkg::*;
(
  input  wire logic              i_clk,
  input  wire pav_pkg::pav_rsp_s i_rsp,
  output pav_pkg::pav_cmd_s      o_cmd
);
  // ************************************************************
  // Command driver
  // ************************************************************
  // Idle between transfers; valid low keeps the block quiet
  initial begin
    o_cmd = '0;
  end

  // One word command; answer has a fixed one-cycle latency, no wait state
  task automatic xfer(input logic wr, input logic [7:0] cd,
                      input logic [15:0] wd, output pav_rsp_s rsp);
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b1, write: wr, code: cd, wdata: wd};
    @(posedge i_clk);
    o_cmd <= '0;
    #1;
    rsp = i_rsp;
  endtask
endmodule // pav_host_model

// [dv/pav_setup_regs_tb.sv]
// Self-checking bench for the setup and bus-address register block.
// Assumes the host model drives commands; the bench drives pins and restore.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin check_count++; if ((sn) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp %h seen %h", nm, ex, sn); end end
module pav_setup_regs_tb;
  import pav_pkg::*;
  logic clk = 0, rst = 1, ld = 0, strap = 0, prim = 0, pin_n = 1;
  logic [3:0] nsetup = 4'h0, mant = 4'h8;
  logic [15:0] naddr = 16'h0000;
  logic [12:0] vout = 13'h0000;
  pav_cmd_s cmd;
  pav_rsp_s rsp, r;
  pav_nvm_s nvm;
  logic [6:0] raddr;
  logic [12:0] vh, vl, th;
  logic boot_act, boot_st, ovf_en, fault;
  int fails = 0, check_count = 0, cyc = 0;
  logic [12:0] tbl [8] = '{13'h02EE, 13'h05DC, 13'h0BB8, 13'h12C0,
                           13'h0384, 13'h0708, 13'h0E10, 13'h1770};

  // ************************************************************
  // Clock, instances, watchdog
  // ************************************************************
  always #5 clk = ~clk;
  pav_host_model i_pav_host_model (.i_clk(clk), .i_rsp(rsp), .o_cmd(cmd));
  pav_setup_regs i_pav_setup_regs (.I_REF_CLK(clk), .I_RST(rst), .I_CMD(cmd),
    .I_NVM_LOAD(ld), .I_NVM_SETUP(nsetup), .I_NVM_ADDR(naddr),
    .I_EXTERNAL_DIVIDER_STATUS_STRAP(strap), .I_IS_PRIMARY(prim), .I_OUT_RST_PIN_N(pin_n),
    .I_LOOP_MANT(mant), .I_VOUT_MV(vout), .O_RSP(rsp), .O_NVM(nvm),
    .O_RESP_ADDR(raddr), .O_OUTPUT_RESET_PIN_VH_MV(vh), .O_OUTPUT_RESET_PIN_VL_MV(vl),
    .O_BOOT_ACTIVE(boot_act), .O_BOOT_START(boot_st), .O_OVF_EN(ovf_en),
    .O_OVF_TH_MV(th), .O_OVERVOLTAGE_FAULT(fault));
  // Tests need well under a thousand cycles; the ceiling leaves margin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      stop_test();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] cd, input logic [15:0] d);
    i_pav_host_model.xfer(1'b1, cd, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] cd, input logic [15:0] ex);
    i_pav_host_model.xfer(1'b0, cd, 16'h0000, r);
    `CHK("rsp_valid", 1'b1, r.valid)
    `CHK("rdata", ex, r.rdata)
  endtask
  // Catch a one-cycle start pulse within a few cycles
  task automatic wait_start(output logic seen);
    seen = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1;
      if (boot_st === 1'b1) seen = 1'b1;
    end
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_setup();
    wr(CMD_SETUP, 16'hFFFF);
    rd_chk(CMD_SETUP, 16'h000F);
    @(posedge clk) strap <= 1'b1;
    wt(2);
    rd_chk(CMD_SETUP, 16'h001F);
    wt(2);
    `CHK("vh_hi", 13'h044C, vh)
    `CHK("vl_hi", 13'h0384, vl)
    `CHK("ovf_off", 1'b0, ovf_en)
    i_pav_host_model.xfer(1'b0, 8'hD4, 16'h0000, r);
    `CHK("nack", 1'b1, r.nack)
  endtask
  task automatic t_ovf();
    for (int i = 0; i < 8; i++) begin
      wr(CMD_SETUP, {14'h0000, i[2], 1'b0});
      @(posedge clk) mant <= 4'h8 >> i[1:0];
      wt(3);
      `CHK("ovf_th", tbl[i], th)
    end
    wr(CMD_SETUP, 16'h0000);
    @(posedge clk) mant <= 4'h8;
    vout <= 13'h02EF;
    wt(3);
    `CHK("ovf_en", 1'b1, ovf_en)
    `CHK("fault_hi", 1'b1, fault)
    @(posedge clk) vout <= 13'h02EE;
    wt(2);
    `CHK("fault_eq", 1'b0, fault)
    wr(CMD_SETUP, 16'h0001);
    @(posedge clk) vout <= 13'h1FFF;
    wt(3);
    `CHK("fault_dis", 1'b0, fault)
  endtask
  task automatic t_addr();
    wr(CMD_ADDR, 16'hD5AA);
    rd_chk(CMD_ADDR, 16'h552A);
    @(posedge clk) prim <= 1'b1;
    wt(2);
    rd_chk(CMD_ADDR, 16'h5555);
    `CHK("old_addr", 7'h00, raddr)
    wr(CMD_STORE_ALL, 16'h0000);
    `CHK("store", 1'b1, nvm.store)
    `CHK("store_img", 16'h5555, nvm.addr)
    `CHK("store_setup", 4'h1, nvm.setup)
    wt(2);
    `CHK("still_old", 7'h00, raddr)
    @(posedge clk) naddr <= 16'h552A;
    ld <= 1'b1;
    @(posedge clk) ld <= 1'b0;
    wt(2);
    `CHK("new_addr", 7'h55, raddr)
  endtask
  task automatic t_boot();
    logic s;
    @(posedge clk) pin_n <= 1'b0;
    wait_start(s);
    `CHK("no_boot", 1'b0, s)
    `CHK("no_act", 1'b0, boot_act)
    @(posedge clk) pin_n <= 1'b1;
    wr(CMD_SETUP, 16'h0004);
    wt(3);
    @(posedge clk) pin_n <= 1'b0;
    wait_start(s);
    `CHK("boot_pin", 1'b1, s)
    `CHK("boot_act", 1'b1, boot_act)
    wr(CMD_SETUP, 16'h0000);
    wt(3);
    fork
      wr(CMD_SETUP, 16'h0004);
      wait_start(s);
    join
    `CHK("boot_en", 1'b1, s)
  endtask

  // ************************************************************
  // Verdict and main sequence
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    wt(11);
    @(posedge clk) rst <= 1'b0;
    wt(1);
    `CHK("vh_rst", 13'h0258, vh)
    `CHK("vl_rst", 13'h01F4, vl)
    t_setup();
    t_ovf();
    t_addr();
    t_boot();
    stop_test();
  end
endmodule // pav_setup_regs_tb
